// ---- hw/ien_map.vh ----
// Address map, field positions and timing constants of the enable block
`ifndef IEN_MAP_VH
`define IEN_MAP_VH
`define IEN_ADDR_ENSET 32'hE000E100
`define IEN_ADDR_ENCLR 32'hE000E180
`define IEN_ADDR_NMIFLG 32'hE000EF00
`define IEN_ADDR_NMIMISS 32'hE000EF04
`define IEN_ADDR_AFSR 32'hE000EF08
`define IEN_ADDR_WDOG 32'hE000EF0C
`define IEN_ADDR_CLK 32'hE000EF10
`define IEN_SEL_ENSET 3'h0
`define IEN_SEL_ENCLR 3'h1
`define IEN_SEL_NMIFLG 3'h2
`define IEN_SEL_NMIMISS 3'h3
`define IEN_SEL_AFSR 3'h4
`define IEN_SEL_WDOG 3'h5
`define IEN_SEL_CLK 3'h6
`define IEN_SEL_NONE 3'h7
`define IEN_RESP_OKAY 2'h0
`define IEN_RESP_SLVERR 2'h2
`define IEN_NUM_IRQ 17
`define IEN_EN_RESET 17'h00000
`define IEN_IRQ_TIMER_ONE 0
`define IEN_IRQ_TIMER_TWO 1
`define IEN_IRQ_MANAGEMENT 2
`define IEN_IRQ_BASEBAND 3
`define IEN_IRQ_SLEEP_TIMER 4
`define IEN_IRQ_SERIAL_ONE 5
`define IEN_IRQ_SERIAL_TWO 6
`define IEN_IRQ_SECURITY 7
`define IEN_IRQ_RADIO_TIMER 8
`define IEN_IRQ_RADIO_TX 9
`define IEN_IRQ_RADIO_RX 10
`define IEN_IRQ_CONVERTER 11
`define IEN_IRQ_EXT_A 12
`define IEN_IRQ_EXT_B 13
`define IEN_IRQ_EXT_C 14
`define IEN_IRQ_EXT_D 15
`define IEN_IRQ_DEBUG 16
`define IEN_NMI_XTAL 0
`define IEN_NMI_WDOG 1
`define IEN_WDOG_EN_BIT 0
`define IEN_WDOG_KICK_BIT 1
`define IEN_CLK_USE_XTAL_BIT 0
`define IEN_CLK_ON_RC_BIT 1
`define IEN_AFSR_WRONG_SIZE 0
`define IEN_AFSR_PROTECTED 1
`define IEN_AFSR_UNMAPPED 2
`define IEN_AFSR_MISSED 3
`define IEN_SIZE_WORD 2'h2
`define IEN_RAM_BASE 32'h20000000
`define IEN_APB_HI 16'h4000
`define IEN_AHB_HI 16'h4001
`define IEN_FLASH_BYTES 32'h00030000
`define IEN_RAM_BYTES 32'h00004000
`define IEN_RAM_PROT_BYTES 32'h00000400
`define IEN_APB_IMPL_BYTES 12'h100
`define IEN_APB_SYS_BLOCK 4'h0
`define IEN_CLK_HZ 20000000
`define IEN_WDOG_LOW_MS 1792
`define IEN_XTAL_FAIL_US 10
`endif

// ---- hw/ien_fault.v ----
// Bus-fault cause classifier and auxiliary fault status
`timescale 1ns/1ns
`include "ien_map.vh"
module ien_fault #(
  parameter [31:0] FLASH_BYTES = `IEN_FLASH_BYTES,
  parameter [31:0] RAM_BYTES = `IEN_RAM_BYTES,
  parameter [31:0] RAM_PROT_BYTES = `IEN_RAM_PROT_BYTES,
  parameter [11:0] APB_IMPL_BYTES = `IEN_APB_IMPL_BYTES
) (
  input wire aclk,
  input wire aresetn,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire [1:0] acc_size,
  input wire acc_write,
  input wire acc_priv,
  input wire [3:0] afsr_clr,
  output reg [3:0] afsr,
  output reg bus_fault,
  output reg hard_fault
);
  wire in_flash = (acc_addr < `IEN_RAM_BASE);
  localparam [31:0] RAM_BASE = `IEN_RAM_BASE;
  wire in_ram = (acc_addr[31:29] == RAM_BASE[31:29]);
  wire [31:0] ram_off = acc_addr - `IEN_RAM_BASE;
  wire in_apb = (acc_addr[31:16] == `IEN_APB_HI);
  wire in_ahb = (acc_addr[31:16] == `IEN_AHB_HI);
  wire sys_apb = in_apb && (acc_addr[15:12] == `IEN_APB_SYS_BLOCK);
  reg [3:0] cause;
  reg [3:0] next_afsr;
  always @* begin
    cause = 4'h0;
    // Wrong width on the peripheral bus, or a misaligned word
    cause[`IEN_AFSR_WRONG_SIZE] = (in_apb && acc_size != `IEN_SIZE_WORD) ||
      (acc_size == `IEN_SIZE_WORD && acc_addr[1:0] != 2'h0);
    cause[`IEN_AFSR_PROTECTED] = acc_write && !acc_priv &&
      (sys_apb || in_ahb || (in_ram && ram_off < RAM_PROT_BYTES));
    cause[`IEN_AFSR_UNMAPPED] =
      (in_apb && acc_addr[11:0] >= APB_IMPL_BYTES) ||
      (in_flash && acc_addr >= FLASH_BYTES) ||
      (in_ram && ram_off >= RAM_BYTES);
    if (!acc_valid)
      cause = 4'h0;
    // A new fault while one is still recorded marks the overlap
    cause[`IEN_AFSR_MISSED] = (|cause) && (|afsr);
    // Set beats clear so a fault in the clearing cycle stays visible
    next_afsr = (afsr & ~afsr_clr) | cause;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      afsr <= 4'h0;
      bus_fault <= 1'b0;
      hard_fault <= 1'b0;
    end else begin
      afsr <= next_afsr;
      // Overlapping fault escalates and preempts the bus fault
      hard_fault <= cause[`IEN_AFSR_MISSED];
      bus_fault <= (|cause) && !cause[`IEN_AFSR_MISSED];
    end
  end
endmodule // ien_fault

// ---- hw/ien_top.v ----
// Top-level interrupt enables, NMI sources and bus-fault status
// Summary of operation
// - NMI comes from event logic, fed only by crystal fail and watchdog.
// - Crystal failure while running on it switches clock to RC oscillator.
// - Crystal-failure flag rises only after detection and switchover finish.
// - Active watchdog left unkicked for low-water interval raises its NMI flag.
// - Bus faults come from this block's own access checks.
// - Each bus-fault cause has its own status bit; several may set.
// - Byte or halfword access to peripheral-bus register flags wrong size.
// - Misaligned word access also flags wrong size.
// - User-mode write to system peripheral or protected RAM flags privilege.
// - Access above last implemented register in peripheral block flags unmapped.
// - Access beyond top of RAM or flash flags unmapped.
// - Second fault sets overlap bit and escalates to hard fault instead.
// - Writing one to enable-set bit enables that line; zero does nothing.
// - Writing one to enable-clear bit disables that line; zero does nothing.
// - Bits 16 debug, 15-12 external D-A, 11 converter, 10-8 radio.
// - Bits 7 security, 6-5 serial, 4 sleep, 3 baseband, 2 mgmt, 1-0 timers.
// - Event in same cycle as its flag clear keeps the flag set.
// - Event recurring on a set flag sets missed bit, write one clears.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ien_map.vh"
module ien_top #(
  parameter [31:0] WDOG_CYC = `IEN_WDOG_LOW_MS * (`IEN_CLK_HZ / 1000),
  parameter [31:0] XTAL_FAIL_CYC = `IEN_XTAL_FAIL_US * (`IEN_CLK_HZ / 1000000),
  parameter [31:0] FLASH_BYTES = `IEN_FLASH_BYTES,
  parameter [31:0] RAM_BYTES = `IEN_RAM_BYTES,
  parameter [31:0] RAM_PROT_BYTES = `IEN_RAM_PROT_BYTES,
  parameter [11:0] APB_IMPL_BYTES = `IEN_APB_IMPL_BYTES
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [31:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [16:0] irq_src,
  output reg [16:0] irq_to_core,
  input wire xtal_ok,
  output reg clk_sel_rc,
  output reg nmi,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire [1:0] acc_size,
  input wire acc_write,
  input wire acc_priv,
  output reg bus_fault,
  output reg hard_fault
);
  localparam N = `IEN_NUM_IRQ;

  // Register select, shared by the read and write paths
  function [2:0] ien_dec;
    input [31:0] addr;
    begin
      case (addr)
        `IEN_ADDR_ENSET: ien_dec = `IEN_SEL_ENSET;
        `IEN_ADDR_ENCLR: ien_dec = `IEN_SEL_ENCLR;
        `IEN_ADDR_NMIFLG: ien_dec = `IEN_SEL_NMIFLG;
        `IEN_ADDR_NMIMISS: ien_dec = `IEN_SEL_NMIMISS;
        `IEN_ADDR_AFSR: ien_dec = `IEN_SEL_AFSR;
        `IEN_ADDR_WDOG: ien_dec = `IEN_SEL_WDOG;
        `IEN_ADDR_CLK: ien_dec = `IEN_SEL_CLK;
        default: ien_dec = `IEN_SEL_NONE;
      endcase
    end
  endfunction

  // Bytes without a strobe contribute zeros, so they set and clear nothing, except an unstrobed byte 0 of a watchdog write, which clears wd_en
  function [31:0] ien_mask;
    input [31:0] d;
    input [3:0] s;
    begin
      ien_mask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  reg [N-1:0] irq_en;
  reg [1:0] nmi_flag;
  reg [1:0] nmi_miss;
  reg wd_en;
  reg [31:0] wd_cnt;
  reg wd_evt;
  reg use_xtal;
  reg [31:0] xf_cnt;
  reg xtal_evt;
  reg xtal_done;
  reg xtal_meta;
  reg xtal_sync;
  wire [3:0] afsr;
  wire fault_bus;
  wire fault_hard;

  // Write channel holding state
  reg aw_full;
  reg w_full;
  reg [31:0] aw_addr_q;
  reg [31:0] w_data_q;
  wire wr_go = aw_full && w_full && !bvalid;
  wire [2:0] wr_sel = ien_dec(aw_addr_q);
  wire [31:0] wr_val = w_data_q;
  wire wr_en_set = wr_go && wr_sel == `IEN_SEL_ENSET;
  wire wr_en_clr = wr_go && wr_sel == `IEN_SEL_ENCLR;
  wire [1:0] nmi_clr = (wr_go && wr_sel == `IEN_SEL_NMIFLG) ?
    wr_val[1:0] : 2'h0;
  wire [1:0] miss_clr = (wr_go && wr_sel == `IEN_SEL_NMIMISS) ?
    wr_val[1:0] : 2'h0;
  wire [3:0] afsr_clr = (wr_go && wr_sel == `IEN_SEL_AFSR) ?
    wr_val[3:0] : 4'h0;
  wire wr_wdog = wr_go && wr_sel == `IEN_SEL_WDOG;
  wire wr_clk = wr_go && wr_sel == `IEN_SEL_CLK;
  wire wd_kick = wr_wdog && wr_val[`IEN_WDOG_KICK_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      bvalid <= 1'b0;
      bresp <= `IEN_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_q <= ien_mask(wdata, wstrb);
        w_full <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (wr_sel == `IEN_SEL_NONE) ? `IEN_RESP_SLVERR :
          `IEN_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read path answers one cycle after the address is taken
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (ien_dec(araddr))
      `IEN_SEL_ENSET, `IEN_SEL_ENCLR: rd_val[N-1:0] = irq_en;
      `IEN_SEL_NMIFLG: rd_val[1:0] = nmi_flag;
      `IEN_SEL_NMIMISS: rd_val[1:0] = nmi_miss;
      `IEN_SEL_AFSR: rd_val[3:0] = afsr;
      `IEN_SEL_WDOG: rd_val[`IEN_WDOG_EN_BIT] = wd_en;
      `IEN_SEL_CLK: begin
        rd_val[`IEN_CLK_USE_XTAL_BIT] = use_xtal;
        rd_val[`IEN_CLK_ON_RC_BIT] = clk_sel_rc;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `IEN_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= (ien_dec(araddr) == `IEN_SEL_NONE) ? `IEN_RESP_SLVERR :
        `IEN_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Enable register and gating of peripheral lines
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= `IEN_EN_RESET;
      irq_to_core <= `IEN_EN_RESET;
    end else begin
      if (wr_en_set)
        irq_en <= irq_en | wr_val[N-1:0];
      else if (wr_en_clr)
        irq_en <= irq_en & ~wr_val[N-1:0];
      irq_to_core <= irq_src & irq_en;
    end
  end

  // Crystal monitor: the pin is asynchronous, so it is synchronised first
  always @(posedge aclk) begin
    if (!aresetn) begin
      xtal_meta <= 1'b1;
      xtal_sync <= 1'b1;
    end else begin
      xtal_meta <= xtal_ok;
      xtal_sync <= xtal_meta;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      use_xtal <= 1'b1;
      clk_sel_rc <= 1'b0;
      xf_cnt <= 32'h00000000;
      xtal_evt <= 1'b0;
    end else begin
      xtal_evt <= 1'b0;
      if (!use_xtal || xtal_sync) begin
        xf_cnt <= 32'h00000000;
      end else if (xf_cnt == XTAL_FAIL_CYC - 32'h1) begin
        // Fall back without waiting for software
        use_xtal <= 1'b0;
        clk_sel_rc <= 1'b1;
        xf_cnt <= 32'h00000000;
      end else begin
        xf_cnt <= xf_cnt + 32'h1;
      end
      // Flag follows the completed switch by one cycle
      if (use_xtal && !clk_sel_rc) begin
        xtal_evt <= 1'b0;
      end else if (!use_xtal && clk_sel_rc && !xtal_evt && xf_cnt == 32'h0
          && !xtal_done) begin
        xtal_evt <= 1'b1;
      end
      // Software may return to the crystal once it is healthy again
      if (wr_clk && wr_val[`IEN_CLK_USE_XTAL_BIT] && xtal_sync) begin
        use_xtal <= 1'b1;
        clk_sel_rc <= 1'b0;
      end
    end
  end

  // One flag per failure episode; rearmed when the crystal is selected
  always @(posedge aclk) begin
    if (!aresetn)
      xtal_done <= 1'b0;
    else if (use_xtal)
      xtal_done <= 1'b0;
    else if (xtal_evt)
      xtal_done <= 1'b1;
  end

  // Watchdog low-water counter; restarts after each event so it can recur
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_en <= 1'b0;
      wd_cnt <= 32'h00000000;
      wd_evt <= 1'b0;
    end else begin
      wd_evt <= 1'b0;
      if (wr_wdog)
        wd_en <= wr_val[`IEN_WDOG_EN_BIT];
      if (!wd_en || wd_kick) begin
        wd_cnt <= 32'h00000000;
      end else if (wd_cnt == WDOG_CYC - 32'h1) begin
        wd_cnt <= 32'h00000000;
        wd_evt <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end

  // Second-level NMI flags and missed-event bits
  wire [1:0] nmi_evt;
  assign nmi_evt[`IEN_NMI_XTAL] = xtal_evt;
  assign nmi_evt[`IEN_NMI_WDOG] = wd_evt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_nmi
      always @(posedge aclk) begin
        if (!aresetn) begin
          nmi_flag[g] <= 1'b0;
          nmi_miss[g] <= 1'b0;
        end else begin
          // Set wins over the clearing write
          nmi_flag[g] <= (nmi_flag[g] & ~nmi_clr[g]) | nmi_evt[g];
          nmi_miss[g] <= (nmi_miss[g] & ~miss_clr[g]) |
            (nmi_evt[g] & nmi_flag[g]);
        end
      end
    end
  endgenerate

  // Never gated by the enable register
  always @(posedge aclk) begin
    if (!aresetn)
      nmi <= 1'b0;
    else
      nmi <= |nmi_flag;
  end

  ien_fault #(
    .FLASH_BYTES(FLASH_BYTES),
    .RAM_BYTES(RAM_BYTES),
    .RAM_PROT_BYTES(RAM_PROT_BYTES),
    .APB_IMPL_BYTES(APB_IMPL_BYTES)
  ) u_fault (
    .aclk(aclk),
    .aresetn(aresetn),
    .acc_valid(acc_valid),
    .acc_addr(acc_addr),
    .acc_size(acc_size),
    .acc_write(acc_write),
    .acc_priv(acc_priv),
    .afsr_clr(afsr_clr),
    .afsr(afsr),
    .bus_fault(fault_bus),
    .hard_fault(fault_hard)
  );

  // Retimed so every output leaves from a local flip-flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_fault <= 1'b0;
      hard_fault <= 1'b0;
    end else begin
      bus_fault <= fault_bus;
      hard_fault <= fault_hard;
    end
  end
endmodule // ien_top

// ---- bench/ien_chk_asserts.sv ----
// Port-level assertions for the interrupt enable block
`timescale 1ns/1ns
module ien_chk (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  input wire [16:0] irq_src,
  input wire [16:0] irq_to_core,
  input wire xtal_ok,
  input wire clk_sel_rc,
  input wire nmi,
  input wire acc_valid,
  input wire bus_fault,
  input wire hard_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid) else $error("write not answered");
  a_bresp_hold: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  a_read_answer: assert property (arvalid && arready
    |=> rvalid && !arready) else $error("read not answered");
  a_rdata_hold: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata)) else $error("read data dropped");
  // A line may only reach the core if its source was high
  a_irq_gated: assert property (
    (irq_to_core & ~$past(irq_src)) == 17'h00000) else $error("line leaked");
  a_rc_on_fail: assert property ($rose(clk_sel_rc)
    |-> !$past(xtal_ok, 4)) else $error("switch without crystal failure");
  a_nmi_follow: assert property ($rose(clk_sel_rc)
    |-> ##[1:3] nmi) else $error("no nmi after switchover");
  a_fault_excl: assert property (
    !(bus_fault && hard_fault)) else $error("both faults at once");
  a_fault_cause: assert property (bus_fault || hard_fault
    |-> $past(acc_valid) || $past(acc_valid, 2)) else $error("fault no access");
  c_bus: cover property (bus_fault);
  c_hard: cover property (hard_fault);
  c_rc: cover property ($rose(clk_sel_rc));
  c_nmi: cover property ($rose(nmi) && !clk_sel_rc);
endmodule // ien_chk

// ---- bench/ien_peer.sv ----
// Peripheral event sources and crystal pin facing the enable block
`timescale 1ns/1ns
module ien_peer (
  input wire aclk,
  input wire [16:0] want_src,
  input wire want_ok,
  output reg [16:0] irq_src,
  output reg xtal_ok
);
  initial irq_src = 17'h00000;
  initial xtal_ok = 1'b1;
  // Same-clock sources only move on the edge, never between edges
  always @(posedge aclk) begin
    irq_src <= want_src;
    xtal_ok <= want_ok;
  end
endmodule // ien_peer

// ---- bench/tb.sv ----
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ns
`include "ien_map.vh"
module tb;
  localparam int WD = 200;
  reg [39:0] ftv;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg [31:0] awaddr, wdata, araddr, acc_addr, seed, d;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [16:0] want_src;
  reg want_ok, acc_valid, acc_write, acc_priv, bf, hf;
  reg [1:0] acc_size, r;
  wire [16:0] irq_src, irq_to_core;
  wire xtal_ok, clk_sel_rc, nmi, bus_fault, hard_fault;
  int err_count, checks_done, en, i, n;

  ien_top #(.WDOG_CYC(WD), .XTAL_FAIL_CYC(8)) dut (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .irq_src, .irq_to_core, .xtal_ok,
    .clk_sel_rc, .nmi, .acc_valid, .acc_addr, .acc_size, .acc_write,
    .acc_priv, .bus_fault, .hard_fault);
  ien_peer u_peer (.aclk, .want_src, .want_ok, .irq_src, .xtal_ok);

  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end

  // Fault cases: expected status, priv, write, size, address
  function [39:0] ft(input int k);
    case (k)
      0: ft = 40'h18_4000_0010;
      1: ft = 40'h1A_2000_0402;
      2: ft = 40'h26_2000_0000;
      3: ft = 40'h4A_4000_1200;
      4: ft = 40'h4A_2000_4000;
      5: ft = 40'h4A_0003_0000;
      default: ft = 40'h75_4000_0101;
    endcase
  endfunction

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task wr(input [31:0] a, input [31:0] dd);
    reg aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    r = bresp;
  endtask

  task rd(input [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    d = rdata;
    r = rresp;
  endtask

  // One access seen by the monitor; fault pulses gathered over two edges
  task acc(input [39:0] t);
    @(posedge aclk);
    {acc_priv, acc_write, acc_size, acc_addr} <= t[35:0];
    acc_valid <= 1;
    @(posedge aclk);
    acc_valid <= 0;
    bf = 0;
    hf = 0;
    repeat (2) begin
      #1;
      bf = bf | bus_fault;
      hf = hf | hard_fault;
      @(posedge aclk);
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    wrap_up;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, acc_valid} = 0;
    {awaddr, wdata, araddr, acc_addr, acc_size, acc_write} = 0;
    {acc_priv, want_src, en} = 0;
    want_ok = 1;
    seed = 32'hCA77;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(`IEN_ADDR_ENCLR);
    chk(d, 0);
    want_src <= 17'h1FFFF;
    for (i = 0; i < 17; i++) begin
      wr(`IEN_ADDR_ENCLR, 32'hFFFFFFFF);
      wr(`IEN_ADDR_ENSET, 1 << i);
      chk(r, `IEN_RESP_OKAY);
      @(posedge aclk);
      #1 chk(irq_to_core, 1 << i);
    end
    en = 32'h10000;
    for (n = 0; n < 16; n++) begin
      seed = lfsr(seed);
      want_src <= seed[24:8];
      if (seed[31]) begin
        wr(`IEN_ADDR_ENCLR, seed);
        en = en & ~seed;
      end else begin
        wr(`IEN_ADDR_ENSET, seed);
        en = (en | seed) & 32'h1FFFF;
      end
      rd(`IEN_ADDR_ENSET);
      chk(d, en);
      rd(`IEN_ADDR_ENCLR);
      #1 chk(irq_to_core, en & seed[24:8]);
      chk(d, en);
    end
    rd(32'hE000E004);
    chk(d, 0);
    chk(r, `IEN_RESP_SLVERR);
    wr(32'hE000E004, 32'hFFFFFFFF);
    chk(r, `IEN_RESP_SLVERR);
    rd(`IEN_ADDR_ENSET);
    chk(d, en);
    chk(nmi, 0);
    want_ok <= 0;
    for (n = 0; n < 60 && !nmi; n++) @(posedge aclk);
    #1 chk(clk_sel_rc, 1);
    chk(nmi, 1);
    rd(`IEN_ADDR_NMIFLG);
    chk(d[1:0], 2'h1);
    want_ok <= 1;
    repeat (4) @(posedge aclk);
    wr(`IEN_ADDR_CLK, 1);
    wr(`IEN_ADDR_NMIFLG, 3);
    rd(`IEN_ADDR_CLK);
    chk(d[1:0], 2'h1);
    #1 chk(nmi, 0);
    wr(`IEN_ADDR_WDOG, 1);
    for (n = 0; n < 400 && !nmi; n++) @(posedge aclk);
    chk(n >= WD - 2 && n <= WD + 4, 1);
    // Clear lands on the edge of the second watchdog event
    repeat (WD - 5) @(posedge aclk);
    wr(`IEN_ADDR_NMIFLG, 2);
    rd(`IEN_ADDR_NMIFLG);
    chk(d[1:0], 2'h2);
    rd(`IEN_ADDR_NMIMISS);
    chk(d[1:0], 2'h2);
    wr(`IEN_ADDR_WDOG, 0);
    wr(`IEN_ADDR_NMIMISS, 3);
    rd(`IEN_ADDR_NMIMISS);
    chk(d[1:0], 0);
    for (i = 0; i < 7; i++) begin
      ftv = ft(i);
      acc(ftv);
      chk({bf, hf}, 2'h2);
      rd(`IEN_ADDR_AFSR);
      chk(d[3:0], ftv[39:36]);
      wr(`IEN_ADDR_AFSR, 32'hF);
    end
    acc(ft(0));
    acc(ft(1));
    chk({bf, hf}, 2'h1);
    rd(`IEN_ADDR_AFSR);
    chk(d[3:0], 4'h9);
    wrap_up;
  end
endmodule // tb

bind ien_top ien_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
  .rready, .irq_src, .irq_to_core, .xtal_ok, .clk_sel_rc, .nmi,
  .acc_valid, .bus_fault, .hard_fault);
